// ---- core/tmr16_map.svh ----
// Operation
// - Wide registers reached as two byte accesses
// - One shared temporary high-byte register
// - Low-byte write loads full word
// - Low-byte read latches high byte
// - Compare reads bypass the temporary byte
// - Write high first, read low first
// - Main code masks interrupts across pairs
// - No clock source means no counting
// - Prescaler or external pin, edge selectable
// - Compares drive waveform pins continuously
// - Compare match sets channel flag
// - Capture edge copies counter to capture
// - Optional noise filter before edge detect
// - Top is fixed, compare A or capture
// - Compare A as top disables PWM A
// - Bottom flagged in dual-slope modes on the tick that moves the counter off zero
// - Top flagged in single-slope modes; top is all ones in normal mode and in unlisted mode 7
// - Power gate bit must be cleared first
// - Five flags, each individually maskable
// - Control registers take plain byte access
// - Processor counter write beats count/clear
`ifndef TMR16_MAP_SVH
`define TMR16_MAP_SVH
// Byte addresses on the 8-bit timer bus
`define TMR16_A_CTL1 6'h00
`define TMR16_A_CTL2 6'h01
`define TMR16_A_CTL3 6'h02
`define TMR16_A_CNT_L 6'h04
`define TMR16_A_CNT_H 6'h05
`define TMR16_A_CAP_L 6'h06
`define TMR16_A_CAP_H 6'h07
`define TMR16_A_CMPA_L 6'h08
`define TMR16_A_CMPA_H 6'h09
`define TMR16_A_CMPB_L 6'h0A
`define TMR16_A_CMPB_H 6'h0B
`define TMR16_A_CMPC_L 6'h0C
`define TMR16_A_CMPC_H 6'h0D
`define TMR16_A_FLAG 6'h10
`define TMR16_A_MASK 6'h11
// Flag bit positions
`define TMR16_F_OVF 0
`define TMR16_F_MA 1
`define TMR16_F_MB 2
`define TMR16_F_MC 3
`define TMR16_F_CAP 5
// Control fields
`define TMR16_CS_LSB 0
`define TMR16_WGM_LSB 3
`define TMR16_CAPEDGE_BIT 6
`define TMR16_FILTER_BIT 7
`define TMR16_POLA_BIT 7
`define TMR16_POLB_BIT 6
`define TMR16_POLC_BIT 5
`define TMR16_CAPSRC_BIT 0
`define TMR16_FILTER_LEN 4
`define TMR16_TOP_8 16'h00FF
`define TMR16_TOP_9 16'h01FF
`define TMR16_TOP_10 16'h03FF
`define TMR16_MAX 16'hFFFF
`define TMR16_BOTTOM 16'h0000
// APB word offsets of the controller
`define TMR16_P_CMD 12'h000
`define TMR16_P_STAT 12'h004
`define TMR16_P_RDATA 12'h008
`define TMR16_P_GATE 12'h00C
`define TMR16_CMD_GO_BIT 31
`define TMR16_CMD_WR_BIT 30
`define TMR16_CMD_WIDE_BIT 29
`endif

// ---- core/tmr16_pkg.sv ----
package tmr16_pkg;
   typedef enum logic [1:0] {
      TMR16_ST_IDLE = 2'b00,
      TMR16_ST_FIRST = 2'b01,
      TMR16_ST_SECOND = 2'b10
   } tmr16_state_type;
   typedef enum logic [1:0] {
      TMR16_TOP_FIXED = 2'b00,
      TMR16_TOP_CMPA = 2'b01,
      TMR16_TOP_CAP = 2'b10,
      TMR16_TOP_MAXV = 2'b11
   } tmr16_top_type;
endpackage

// ---- core/tmr16_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface tmr16_if;
   logic [5:0] addr;
   logic wr;
   logic rd;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic power_gate;
   modport device (input addr, input wr, input rd, input wdata, input power_gate,
      output rdata);
   modport host (output addr, output wr, output rd, output wdata, output power_gate,
      input rdata);
endinterface
`default_nettype wire

// ---- core/tmr16_prescaler.sv ----
`timescale 1ns/1ns
`default_nettype none
module tmr16_prescaler (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [2:0] sel,
   input wire logic ext_pin,
   output logic tick
);
   logic [9:0] div_q;
   logic ext_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) div_q <= 10'h000;
      else if (run) div_q <= div_q + 10'h001;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ext_q <= 1'b0;
      else ext_q <= ext_pin;
   end
   always_comb begin
      unique case (sel)
         3'h0: tick = 1'b0;
         3'h1: tick = run;
         3'h2: tick = run && (div_q[2:0] == 3'h7);
         3'h3: tick = run && (div_q[5:0] == 6'h3F);
         3'h4: tick = run && (div_q[7:0] == 8'hFF);
         3'h5: tick = run && (div_q == 10'h3FF);
         3'h6: tick = run && ext_q && !ext_pin;
         3'h7: tick = run && !ext_q && ext_pin;
      endcase
   end
endmodule
`default_nettype wire

// ---- core/tmr16_device.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "tmr16_map.svh"
module tmr16_device
   import tmr16_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   tmr16_if.device bus,
   input wire logic external_count_pin,
   input wire logic capture_input_pin,
   input wire logic comparator_out,
   output logic wave_out_a,
   output logic wave_out_b,
   output logic wave_out_c,
   output logic timer_irq
);
   logic [15:0] counter_value_q, compare_value_a_q, compare_value_b_q, compare_value_c_q;
   logic [15:0] cmp_buf_a_q, cmp_buf_b_q, cmp_buf_c_q, capture_value_q;
   logic [7:0] temp_q, timer_control_first_q, timer_control_second_q, timer_control_third_q;
   logic [7:0] timer_flag_register_q, timer_mask_register_q;
   logic [7:0] rdata_q;
   logic [3:0] filt_q;
   logic cap_lvl_q, cap_prev_q, up_q;
   logic wa_q, wb_q, wc_q;
   logic tick, run, pwm, dual, at_top, at_bot;
   logic [15:0] top;
   logic [2:0] wgm;
   logic cap_raw, cap_edge;
   logic wr_cnt;
   logic [2:0] match;
   assign run = !bus.power_gate;
   assign wgm = timer_control_first_q[`TMR16_WGM_LSB +: 3];
   // CTC and normal stay non-pwm so their compare buffers load at once
   assign pwm = wgm inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
   assign dual = (wgm == 3'h5) || (wgm == 3'h6);
   tmr16_prescaler u_presc (
      .pclk(pclk),
      .presetn(presetn),
      .run(run),
      .sel(timer_control_second_q[`TMR16_CS_LSB +: 3]),
      .ext_pin(external_count_pin),
      .tick(tick)
   );
   // Mode decode: 0 normal, 1/2/3 fixed 8/9/10 bit pwm, 4 CTC cmpA, 5 pwm cmpA, 6 pwm cap
   always_comb begin
      unique case (wgm)
         3'h1: top = `TMR16_TOP_8;
         3'h2: top = `TMR16_TOP_9;
         3'h3: top = `TMR16_TOP_10;
         3'h4, 3'h5: top = compare_value_a_q;
         3'h6: top = capture_value_q;
         default: top = `TMR16_MAX;
      endcase
   end
   assign at_top = counter_value_q == top;
   assign at_bot = counter_value_q == `TMR16_BOTTOM;
   assign wr_cnt = bus.wr && bus.addr == `TMR16_A_CNT_L;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_value_q <= 16'h0000;
         up_q <= 1'b1;
      end else if (wr_cnt) begin
         counter_value_q <= {temp_q, bus.wdata};
      end else if (tick) begin
         if (wgm == 3'h5 || wgm == 3'h6) begin
            // Dual-slope so the pin edges stay glitch free
            if (up_q && at_top) begin
               up_q <= 1'b0;
               counter_value_q <= counter_value_q - 16'h0001;
            end else if (!up_q && at_bot) begin
               up_q <= 1'b1;
               counter_value_q <= counter_value_q + 16'h0001;
            end else begin
               counter_value_q <= up_q ? counter_value_q + 16'h0001
                  : counter_value_q - 16'h0001;
            end
         end else begin
            up_q <= 1'b1;
            counter_value_q <= at_top ? 16'h0000 : counter_value_q + 16'h0001;
         end
      end
   end
   // Compare buffers load the active copy at top, or at once outside pwm
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_buf_a_q <= 16'h0000;
         cmp_buf_b_q <= 16'h0000;
         cmp_buf_c_q <= 16'h0000;
         compare_value_a_q <= 16'h0000;
         compare_value_b_q <= 16'h0000;
         compare_value_c_q <= 16'h0000;
      end else begin
         if (bus.wr && bus.addr == `TMR16_A_CMPA_L) cmp_buf_a_q <= {temp_q, bus.wdata};
         if (bus.wr && bus.addr == `TMR16_A_CMPB_L) cmp_buf_b_q <= {temp_q, bus.wdata};
         if (bus.wr && bus.addr == `TMR16_A_CMPC_L) cmp_buf_c_q <= {temp_q, bus.wdata};
         if (!pwm || (tick && at_top)) begin
            compare_value_a_q <= cmp_buf_a_q;
            compare_value_b_q <= cmp_buf_b_q;
            compare_value_c_q <= cmp_buf_c_q;
         end
      end
   end
   assign match[0] = tick && counter_value_q == compare_value_a_q;
   assign match[1] = tick && counter_value_q == compare_value_b_q;
   assign match[2] = tick && counter_value_q == compare_value_c_q;
   // Waveforms: toggle on match outside pwm, set/clear in pwm
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wa_q <= 1'b0;
         wb_q <= 1'b0;
         wc_q <= 1'b0;
      end else if (pwm) begin
         wa_q <= (wgm == 3'h5) ? 1'b0 : (counter_value_q < compare_value_a_q);
         wb_q <= counter_value_q < compare_value_b_q;
         wc_q <= counter_value_q < compare_value_c_q;
      end else begin
         if (match[0]) wa_q <= !wa_q;
         if (match[1]) wb_q <= !wb_q;
         if (match[2]) wc_q <= !wc_q;
      end
   end
   assign wave_out_a = wa_q ^ timer_control_third_q[`TMR16_POLA_BIT];
   assign wave_out_b = wb_q ^ timer_control_third_q[`TMR16_POLB_BIT];
   assign wave_out_c = wc_q ^ timer_control_third_q[`TMR16_POLC_BIT];
   // Capture source, optional four-sample agreement filter
   assign cap_raw = timer_control_third_q[`TMR16_CAPSRC_BIT] ? comparator_out
      : capture_input_pin;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_q <= 4'h0;
         cap_lvl_q <= 1'b0;
         cap_prev_q <= 1'b0;
      end else begin
         filt_q <= {filt_q[2:0], cap_raw};
         if (!timer_control_second_q[`TMR16_FILTER_BIT]) cap_lvl_q <= cap_raw;
         else if (filt_q == 4'hF || filt_q == 4'h0) cap_lvl_q <= filt_q[0];
         cap_prev_q <= cap_lvl_q;
      end
   end
   assign cap_edge = run && (timer_control_second_q[`TMR16_CAPEDGE_BIT]
      ? (cap_lvl_q && !cap_prev_q) : (!cap_lvl_q && cap_prev_q));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) capture_value_q <= 16'h0000;
      else if (bus.wr && bus.addr == `TMR16_A_CAP_L && wgm == 3'h6)
         capture_value_q <= {temp_q, bus.wdata};
      else if (cap_edge && wgm != 3'h6) capture_value_q <= counter_value_q;
   end
   // Shared temporary byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) temp_q <= 8'h00;
      else if (bus.wr && (bus.addr == `TMR16_A_CNT_H || bus.addr == `TMR16_A_CAP_H
         || bus.addr == `TMR16_A_CMPA_H || bus.addr == `TMR16_A_CMPB_H
         || bus.addr == `TMR16_A_CMPC_H)) temp_q <= bus.wdata;
      else if (bus.rd && bus.addr == `TMR16_A_CNT_L) temp_q <= counter_value_q[15:8];
      else if (bus.rd && bus.addr == `TMR16_A_CAP_L) temp_q <= capture_value_q[15:8];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_control_first_q <= 8'h00;
         timer_control_second_q <= 8'h00;
         timer_control_third_q <= 8'h00;
         timer_mask_register_q <= 8'h00;
      end else if (bus.wr) begin
         if (bus.addr == `TMR16_A_CTL1) timer_control_first_q <= bus.wdata;
         if (bus.addr == `TMR16_A_CTL2) timer_control_second_q <= bus.wdata;
         if (bus.addr == `TMR16_A_CTL3) timer_control_third_q <= bus.wdata;
         if (bus.addr == `TMR16_A_MASK) timer_mask_register_q <= bus.wdata & 8'h2F;
      end
   end
   // Flags: hardware set wins over write-one-to-clear
   logic [7:0] set_v, clr_v;
   always_comb begin
      set_v = 8'h00;
      set_v[`TMR16_F_OVF] = tick && (dual ? at_bot : at_top) && !wr_cnt;
      set_v[`TMR16_F_MA] = match[0];
      set_v[`TMR16_F_MB] = match[1];
      set_v[`TMR16_F_MC] = match[2];
      set_v[`TMR16_F_CAP] = cap_edge || (wgm == 3'h6 && tick && at_top);
      clr_v = (bus.wr && bus.addr == `TMR16_A_FLAG) ? bus.wdata : 8'h00;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) timer_flag_register_q <= 8'h00;
      else timer_flag_register_q <= ((timer_flag_register_q & ~clr_v) | set_v) & 8'h2F;
   end
   assign timer_irq = |(timer_flag_register_q & timer_mask_register_q);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rdata_q <= 8'h00;
      else if (bus.rd) begin
         unique case (bus.addr)
            `TMR16_A_CTL1: rdata_q <= timer_control_first_q;
            `TMR16_A_CTL2: rdata_q <= timer_control_second_q;
            `TMR16_A_CTL3: rdata_q <= timer_control_third_q;
            `TMR16_A_CNT_L: rdata_q <= counter_value_q[7:0];
            `TMR16_A_CAP_L: rdata_q <= capture_value_q[7:0];
            `TMR16_A_CNT_H, `TMR16_A_CAP_H: rdata_q <= temp_q;
            `TMR16_A_CMPA_L: rdata_q <= cmp_buf_a_q[7:0];
            `TMR16_A_CMPA_H: rdata_q <= cmp_buf_a_q[15:8];
            `TMR16_A_CMPB_L: rdata_q <= cmp_buf_b_q[7:0];
            `TMR16_A_CMPB_H: rdata_q <= cmp_buf_b_q[15:8];
            `TMR16_A_CMPC_L: rdata_q <= cmp_buf_c_q[7:0];
            `TMR16_A_CMPC_H: rdata_q <= cmp_buf_c_q[15:8];
            `TMR16_A_FLAG: rdata_q <= timer_flag_register_q;
            `TMR16_A_MASK: rdata_q <= timer_mask_register_q;
            default: rdata_q <= 8'h00;
         endcase
      end
   end
   assign bus.rdata = rdata_q;
endmodule
`default_nettype wire

// ---- core/tmr16_host.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "tmr16_map.svh"
module tmr16_host
   import tmr16_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   tmr16_if.host bus
);
   tmr16_state_type state_q;
   logic [5:0] addr_q;
   logic wr_q, wide_q, busy_q, gate_q;
   logic [15:0] data_q, rd_q;
   logic [5:0] a_o;
   logic w_o, r_o;
   logic [7:0] wd_o;
   logic cmd_wr;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign cmd_wr = psel && penable && pwrite && paddr == `TMR16_P_CMD;
   // Sequencer issues both bytes back to back so no other access intervenes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= TMR16_ST_IDLE;
         addr_q <= 6'h00;
         wr_q <= 1'b0;
         wide_q <= 1'b0;
         data_q <= 16'h0000;
         busy_q <= 1'b0;
      end else begin
         unique case (state_q)
            TMR16_ST_IDLE: if (cmd_wr && pwdata[`TMR16_CMD_GO_BIT]) begin
               addr_q <= pwdata[21:16];
               wr_q <= pwdata[`TMR16_CMD_WR_BIT];
               wide_q <= pwdata[`TMR16_CMD_WIDE_BIT];
               data_q <= pwdata[15:0];
               busy_q <= 1'b1;
               state_q <= TMR16_ST_FIRST;
            end
            TMR16_ST_FIRST: begin
               if (wide_q) state_q <= TMR16_ST_SECOND;
               else begin
                  state_q <= TMR16_ST_IDLE;
                  busy_q <= 1'b0;
               end
            end
            TMR16_ST_SECOND: begin
               state_q <= TMR16_ST_IDLE;
               busy_q <= 1'b0;
            end
            default: state_q <= TMR16_ST_IDLE;
         endcase
      end
   end
   // Wide writes go high then low, wide reads low then high
   always_comb begin
      a_o = 6'h00;
      w_o = 1'b0;
      r_o = 1'b0;
      wd_o = 8'h00;
      if (state_q == TMR16_ST_FIRST) begin
         a_o = (wide_q && wr_q) ? (addr_q | 6'h01) : addr_q;
         w_o = wr_q;
         r_o = !wr_q;
         wd_o = (wide_q && wr_q) ? data_q[15:8] : data_q[7:0];
      end else if (state_q == TMR16_ST_SECOND) begin
         a_o = wr_q ? (addr_q & 6'h3E) : (addr_q | 6'h01);
         w_o = wr_q;
         r_o = !wr_q;
         wd_o = data_q[7:0];
      end
   end
   assign bus.addr = a_o;
   assign bus.wr = w_o;
   assign bus.rd = r_o;
   assign bus.wdata = wd_o;
   assign bus.power_gate = gate_q;
   // Device read data appears one cycle after the strobe
   logic [1:0] rd_st_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_st_q <= 2'b00;
         rd_q <= 16'h0000;
      end else begin
         rd_st_q <= {state_q == TMR16_ST_SECOND && !wr_q,
            state_q == TMR16_ST_FIRST && !wr_q};
         if (rd_st_q[0]) rd_q[7:0] <= bus.rdata;
         if (rd_st_q[1]) rd_q[15:8] <= bus.rdata;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) gate_q <= 1'b1;
      else if (psel && penable && pwrite && paddr == `TMR16_P_GATE)
         gate_q <= pwdata[0];
   end
   always_comb begin
      prdata = 32'h0000_0000;
      unique case (paddr)
         `TMR16_P_STAT: prdata = {31'h0000_0000, busy_q || rd_st_q != 2'b00};
         `TMR16_P_RDATA: prdata = {16'h0000, rd_q};
         `TMR16_P_GATE: prdata = {31'h0000_0000, gate_q};
         default: prdata = 32'h0000_0000;
      endcase
   end
endmodule
`default_nettype wire

// ---- testbench/tmr16_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module tmr16_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [5:0] addr,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic power_gate
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic wide_hi;
   logic wide_lo;
   assign wide_hi = (addr >= 6'h04) && (addr <= 6'h0D) && addr[0];
   assign wide_lo = (addr >= 6'h04) && (addr <= 6'h0D) && !addr[0];
   sequence s_high_wr;
      wr && wide_hi;
   endsequence
   sequence s_low_wr_next;
      wr && !rd && (addr == $past(addr) - 6'h01);
   endsequence
   sequence s_low_rd;
      rd && wide_lo;
   endsequence
   sequence s_high_rd_next;
      rd && !wr && (addr == $past(addr) + 6'h01);
   endsequence
   AST_WR_HIGH_THEN_LOW: assert property (s_high_wr |=> s_low_wr_next)
      else $error("wide write did not finish with its low byte");
   AST_RD_LOW_THEN_HIGH: assert property (s_low_rd |=> s_high_rd_next)
      else $error("wide read did not finish with its high byte");
   AST_STROBE_EXCL: assert property (!(wr && rd))
      else $error("read and write strobes together");
   AST_WR_PAIR_ONLY: assert property (wr ##1 wr |=> !wr)
      else $error("more than two byte writes in a row");
   AST_RD_PAIR_ONLY: assert property (rd ##1 rd |=> !rd)
      else $error("more than two byte reads in a row");
   // Read data may only move on the cycle after a read strobe
   AST_RDATA_HOLD: assert property (!rd |=> $stable(rdata))
      else $error("read data changed without a read");
   AST_GATE_AT_RESET: assert property ($rose(presetn) |-> power_gate)
      else $error("power gate not set out of reset");
   AST_IDLE_AFTER_RESET: assert property ($rose(presetn) |-> (!wr && !rd) [*2])
      else $error("strobe active right after reset");
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ext_pin = 1'b0;
   logic cap_pin = 1'b0;
   logic cmp_out = 1'b0;
   logic wave_a;
   logic wave_b;
   logic wave_c;
   logic irq;
   int err_total = 0;
   int checks_done = 0;
   tmr16_if link();
   tmr16_host u_tmr16_host(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus(link));
   tmr16_device u_tmr16_device(.pclk(pclk), .presetn(presetn), .bus(link),
      .external_count_pin(ext_pin), .capture_input_pin(cap_pin), .comparator_out(cmp_out),
      .wave_out_a(wave_a), .wave_out_b(wave_b), .wave_out_c(wave_c), .timer_irq(irq));
   tmr16_checker u_tmr16_checker(.pclk(pclk), .presetn(presetn), .addr(link.addr),
      .wr(link.wr), .rd(link.rd), .wdata(link.wdata), .rdata(link.rdata),
      .power_gate(link.power_gate));
   always #20 pclk = ~pclk;
   task automatic wrap_up;
      $display("checks=%0d errors=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      `CHK(pslverr, 1'b0)
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // One controller command; polls busy so the next command is never refused
   task automatic op(input logic w, input logic wide, input logic [5:0] a,
      input logic [15:0] d, output logic [15:0] r);
      logic [31:0] v;
      apb(1'b1, 12'h000, {1'b1, w, wide, 7'h00, a, d}, v);
      do begin
         apb(1'b0, 12'h004, 32'h0, v);
      end while (v[0] !== 1'b0);
      apb(1'b0, 12'h008, 32'h0, v);
      r = v[15:0];
   endtask
   task automatic put(input logic wide, input logic [5:0] a, input logic [15:0] d);
      logic [15:0] r;
      op(1'b1, wide, a, d, r);
   endtask
   task automatic get(input logic wide, input logic [5:0] a, output logic [15:0] r);
      op(1'b0, wide, a, 16'h0000, r);
   endtask
   task automatic t_reset;
      logic [15:0] r;
      logic [31:0] v;
      `CHK(link.power_gate, 1'b1)
      for (int a = 4; a < 14; a += 2) begin
         get(1'b1, a[5:0], r);
         `CHK(r, 16'h0000)
      end
      apb(1'b0, 12'h00C, 32'h0, v);
      `CHK(v[0], 1'b1)
      get(1'b0, 6'h20, r);
      `CHK(r[7:0], 8'h00)
      apb(1'b1, 12'h00C, 32'h0, v);
      tick(1);
      `CHK(link.power_gate, 1'b0)
   endtask
   task automatic t_ctrl;
      logic [15:0] r;
      put(1'b0, 6'h02, 16'h00E0);
      tick(1);
      `CHK({wave_a, wave_b, wave_c}, 3'b111)
      get(1'b0, 6'h02, r);
      `CHK(r[7:0], 8'hE0)
      put(1'b0, 6'h00, 16'h0018);
      get(1'b0, 6'h00, r);
      `CHK(r[7:0], 8'h18)
      put(1'b0, 6'h00, 16'h0000);
      put(1'b0, 6'h02, 16'h0000);
   endtask
   task automatic t_wide;
      logic [15:0] r;
      logic [5:0] adr [4] = '{6'h04, 6'h08, 6'h0A, 6'h0C};
      logic [15:0] val [4] = '{16'h01FF, 16'h1234, 16'hA55A, 16'h8001};
      for (int i = 0; i < 4; i++) put(1'b1, adr[i], val[i]);
      for (int i = 0; i < 4; i++) begin
         get(1'b1, adr[i], r);
         `CHK(r, val[i])
      end
   endtask
   task automatic t_temp;
      logic [15:0] r;
      put(1'b1, 6'h04, 16'h1234);
      put(1'b0, 6'h0A, 16'h0056);
      get(1'b1, 6'h0A, r);
      `CHK(r, 16'h1256)
      put(1'b1, 6'h0C, 16'h9ABC);
      get(1'b1, 6'h04, r);
      `CHK(r, 16'h1234)
      get(1'b1, 6'h0C, r);
      `CHK(r, 16'h9ABC)
      put(1'b0, 6'h08, 16'h0077);
      get(1'b1, 6'h08, r);
      `CHK(r, 16'h1277)
   endtask
   task automatic t_count;
      logic [15:0] r;
      put(1'b1, 6'h08, 16'h0010);
      put(1'b1, 6'h0A, 16'h0020);
      put(1'b1, 6'h0C, 16'h0030);
      put(1'b1, 6'h04, 16'h0000);
      put(1'b0, 6'h10, 16'h002F);
      tick(50);
      get(1'b1, 6'h04, r);
      `CHK(r, 16'h0000)
      put(1'b0, 6'h01, 16'h0001);
      tick(60);
      put(1'b0, 6'h01, 16'h0000);
      `CHK({wave_a, wave_b, wave_c}, 3'b111)
      get(1'b0, 6'h10, r);
      `CHK(r[7:0], 8'h0E)
      put(1'b0, 6'h11, 16'h0004);
      tick(1);
      `CHK(irq, 1'b1)
      put(1'b0, 6'h10, 16'h0004);
      tick(1);
      `CHK(irq, 1'b0)
      get(1'b0, 6'h10, r);
      `CHK(r[7:0], 8'h0A)
      put(1'b1, 6'h04, 16'hFFF0);
      put(1'b0, 6'h10, 16'h002F);
      put(1'b0, 6'h01, 16'h0001);
      tick(30);
      put(1'b1, 6'h04, 16'h0100);
      put(1'b0, 6'h01, 16'h0000);
      get(1'b1, 6'h04, r);
      `CHK(r >= 16'h0100 && r < 16'h0140, 1'b1)
      get(1'b0, 6'h10, r);
      `CHK(r[0], 1'b1)
      put(1'b1, 6'h04, 16'h0000);
      put(1'b0, 6'h01, 16'h0002);
      tick(80);
      put(1'b0, 6'h01, 16'h0000);
      get(1'b1, 6'h04, r);
      `CHK(r >= 16'd10 && r <= 16'd15, 1'b1)
   endtask
   task automatic t_ext;
      logic [15:0] r;
      for (int m = 0; m < 2; m++) begin
         put(1'b1, 6'h04, 16'h0000);
         put(1'b0, 6'h01, m ? 16'h0006 : 16'h0007);
         repeat (5) begin
            ext_pin <= 1'b1;
            tick(4);
            ext_pin <= 1'b0;
            tick(4);
         end
         put(1'b0, 6'h01, 16'h0000);
         get(1'b1, 6'h04, r);
         `CHK(r, 16'h0005)
      end
   endtask
   task automatic t_capture;
      logic [15:0] r;
      put(1'b0, 6'h01, 16'h0040);
      put(1'b1, 6'h04, 16'h0ABC);
      put(1'b0, 6'h10, 16'h002F);
      cap_pin <= 1'b1;
      tick(10);
      get(1'b1, 6'h06, r);
      `CHK(r, 16'h0ABC)
      get(1'b0, 6'h10, r);
      `CHK(r[5], 1'b1)
      cap_pin <= 1'b0;
      put(1'b1, 6'h04, 16'h0DEF);
      put(1'b0, 6'h01, 16'h00C0);
      cap_pin <= 1'b1;
      tick(2);
      cap_pin <= 1'b0;
      tick(10);
      get(1'b1, 6'h06, r);
      `CHK(r, 16'h0ABC)
      cap_pin <= 1'b1;
      tick(10);
      get(1'b1, 6'h06, r);
      `CHK(r, 16'h0DEF)
      cap_pin <= 1'b0;
      put(1'b0, 6'h02, 16'h0001);
      put(1'b1, 6'h04, 16'h0123);
      cmp_out <= 1'b1;
      tick(10);
      get(1'b1, 6'h06, r);
      `CHK(r, 16'h0123)
      cmp_out <= 1'b0;
   endtask
   // Generous ceiling; the full sequence needs about a thousand cycles
   initial begin
      #(40 * 40000);
      err_total++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_ctrl();
      t_wide();
      t_temp();
      t_count();
      t_ext();
      t_capture();
      wrap_up();
   end
endmodule
`default_nettype wire
